// *** include/range_regs_pkg.sv ***
package range_regs_pkg;

  // ----------------------------------------------------------------
  // bus and word layout
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 7;   // register address width
  localparam int DATA_W   = 16;  // register word width
  localparam int CODE_W   = 2;   // one channel range field
  localparam int CH_PER_R = 4;   // channel fields per register
  localparam int NUM_CH   = 8;   // channels of the second converter

  localparam int ADDR_MSB = 15;  // address field top bit
  localparam int ADDR_LSB = 9;   // address field bottom bit
  localparam int RSVD_BIT = 8;   // stored, no function
  localparam int CH0_LSB  = 0;   // first channel field position
  localparam int CH1_LSB  = 2;
  localparam int CH2_LSB  = 4;
  localparam int CH3_LSB  = 6;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] B_RANGE_LOW_ADDR  = 7'h06;
  localparam logic [ADDR_W-1:0] B_RANGE_HIGH_ADDR = 7'h07;
  localparam logic [DATA_W-1:0] B_RANGE_RESET     = 16'h00FF;
  localparam logic [DATA_W-1:0] READ_IDLE         = 16'h0000;

  // ----------------------------------------------------------------
  // range codes
  // ----------------------------------------------------------------
  typedef enum logic [CODE_W-1:0] {
    RANGE_10V_LOW = 2'h0,
    RANGE_2V5     = 2'h1,
    RANGE_5V      = 2'h2,
    RANGE_10V     = 2'h3
  } range_code_t;

endpackage

// *** rtl/b_side_input_range_regs.sv ***
// Notes on behaviour
// - register at address 0x06 for channels 0 to 3, resets to 0x00FF.
// - register at address 0x07 for channels 4 to 7, resets to 0x00FF.
// - bits 15:9 of each word carry the register address; a write is stored only if it matches addr_in.
// - code 00 and 11 give 10 V, 01 gives 2.5 V, 10 gives 5 V.
// - low register: channel 0 bits 1:0 up to channel 3 bits 7:6.
// - high register: channel 4 bits 1:0 up to channel 7 bits 7:6.
// - range fields reset to code 3; address and reserved bits reset to zero.
// - all range fields read back the last written code.
module b_side_input_range_regs (
  input  wire logic                                clock_in,            // 25 MHz clock
  input  wire logic                                sys_rst_in,          // async reset, active high
  input  wire logic [range_regs_pkg::ADDR_W-1:0]   addr_in,             // register address
  input  wire logic [range_regs_pkg::DATA_W-1:0]   wr_data_in,          // write word
  input  wire logic                                wr_strobe_in,        // one-cycle write
  input  wire logic                                rd_strobe_in,        // one-cycle read
  output logic      [range_regs_pkg::DATA_W-1:0]   rd_data_out,         // read word, next cycle
  output logic                                     rd_valid_out,        // marks rd_data_out
  output logic                                     wr_done_out,         // write was stored
  output logic                                     wr_refused_out,      // write was dropped
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch0_range_out, // channel 0 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch1_range_out, // channel 1 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch2_range_out, // channel 2 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch3_range_out, // channel 3 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch4_range_out, // channel 4 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch5_range_out, // channel 5 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch6_range_out, // channel 6 code
  output logic      [range_regs_pkg::CODE_W-1:0]   second_conv_ch7_range_out, // channel 7 code
  output logic      [range_regs_pkg::NUM_CH-1:0]   span_10v_out,        // per channel, 10 V span
  output logic      [range_regs_pkg::NUM_CH-1:0]   span_5v_out,         // per channel, 5 V span
  output logic      [range_regs_pkg::NUM_CH-1:0]   span_2v5_out         // per channel, 2.5 V span
);

  // ----------------------------------------------------------------
  // storage and decode signals
  // ----------------------------------------------------------------
  logic [range_regs_pkg::DATA_W-1:0]  b_input_range_low_reg;
  logic [range_regs_pkg::DATA_W-1:0]  b_input_range_high_reg;
  logic [range_regs_pkg::ADDR_W-1:0]  word_addr;
  logic                               addr_match;
  logic                               hit_low;
  logic                               hit_high;
  logic                               wr_low;
  logic                               wr_high;
  logic                               wr_take;
  logic [range_regs_pkg::DATA_W-1:0]  rd_data_next;
  logic [range_regs_pkg::CODE_W*range_regs_pkg::NUM_CH-1:0] code_vec;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // address carried in the word itself
  assign word_addr  = wr_data_in[range_regs_pkg::ADDR_MSB:range_regs_pkg::ADDR_LSB];
  // port address and embedded address must agree
  assign addr_match = (word_addr == addr_in);
  assign hit_low    = (addr_in == range_regs_pkg::B_RANGE_LOW_ADDR);
  assign hit_high   = (addr_in == range_regs_pkg::B_RANGE_HIGH_ADDR);

  // write selects only when the embedded address names the register
  assign wr_low  = wr_strobe_in && addr_match && hit_low;
  assign wr_high = wr_strobe_in && addr_match && hit_high;
  assign wr_take = wr_low || wr_high;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------

  // channels 0 to 3, whole word kept including bit 8
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      b_input_range_low_reg <= range_regs_pkg::B_RANGE_RESET;
    end else if (wr_low) begin
      b_input_range_low_reg <= wr_data_in;
    end
  end

  // channels 4 to 7, whole word kept including bit 8
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      b_input_range_high_reg <= range_regs_pkg::B_RANGE_RESET;
    end else if (wr_high) begin
      b_input_range_high_reg <= wr_data_in;
    end
  end

  // ----------------------------------------------------------------
  // write status
  // ----------------------------------------------------------------

  // one-cycle pulses after each write strobe
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_done_out    <= 1'b0;
      wr_refused_out <= 1'b0;
    end else begin
      wr_done_out    <= wr_take;
      wr_refused_out <= wr_strobe_in && !wr_take;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // select stored word, unmapped reads give zero
  always_comb begin
    rd_data_next = range_regs_pkg::READ_IDLE;
    if (rd_strobe_in && hit_low) begin
      rd_data_next = b_input_range_low_reg;
    end else if (rd_strobe_in && hit_high) begin
      rd_data_next = b_input_range_high_reg;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out  <= range_regs_pkg::READ_IDLE;
      rd_valid_out <= 1'b0;
    end else begin
      rd_data_out  <= rd_data_next;
      rd_valid_out <= rd_strobe_in;
    end
  end

  // ----------------------------------------------------------------
  // channel fields
  // ----------------------------------------------------------------

  // low register fields, bit 8 deliberately unused
  assign code_vec[1:0] =
    b_input_range_low_reg[range_regs_pkg::CH0_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[3:2] =
    b_input_range_low_reg[range_regs_pkg::CH1_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[5:4] =
    b_input_range_low_reg[range_regs_pkg::CH2_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[7:6] =
    b_input_range_low_reg[range_regs_pkg::CH3_LSB +: range_regs_pkg::CODE_W];

  // high register fields
  assign code_vec[9:8] =
    b_input_range_high_reg[range_regs_pkg::CH0_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[11:10] =
    b_input_range_high_reg[range_regs_pkg::CH1_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[13:12] =
    b_input_range_high_reg[range_regs_pkg::CH2_LSB +: range_regs_pkg::CODE_W];
  assign code_vec[15:14] =
    b_input_range_high_reg[range_regs_pkg::CH3_LSB +: range_regs_pkg::CODE_W];

  // raw codes straight from the stored words
  assign second_conv_ch0_range_out = code_vec[1:0];
  assign second_conv_ch1_range_out = code_vec[3:2];
  assign second_conv_ch2_range_out = code_vec[5:4];
  assign second_conv_ch3_range_out = code_vec[7:6];
  assign second_conv_ch4_range_out = code_vec[9:8];
  assign second_conv_ch5_range_out = code_vec[11:10];
  assign second_conv_ch6_range_out = code_vec[13:12];
  assign second_conv_ch7_range_out = code_vec[15:14];

  // ----------------------------------------------------------------
  // span decode, one decoder per channel
  // ----------------------------------------------------------------

  // channel 0 decoder; all spans lag the code by one cycle
  range_decode u_dec_ch0 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[1:0]),
    .span_10v_out (span_10v_out[0]),
    .span_5v_out  (span_5v_out[0]),
    .span_2v5_out (span_2v5_out[0])
  );

  // channel 1 decoder
  range_decode u_dec_ch1 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[3:2]),
    .span_10v_out (span_10v_out[1]),
    .span_5v_out  (span_5v_out[1]),
    .span_2v5_out (span_2v5_out[1])
  );

  // channel 2 decoder
  range_decode u_dec_ch2 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[5:4]),
    .span_10v_out (span_10v_out[2]),
    .span_5v_out  (span_5v_out[2]),
    .span_2v5_out (span_2v5_out[2])
  );

  // channel 3 decoder
  range_decode u_dec_ch3 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[7:6]),
    .span_10v_out (span_10v_out[3]),
    .span_5v_out  (span_5v_out[3]),
    .span_2v5_out (span_2v5_out[3])
  );

  // channel 4 decoder
  range_decode u_dec_ch4 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[9:8]),
    .span_10v_out (span_10v_out[4]),
    .span_5v_out  (span_5v_out[4]),
    .span_2v5_out (span_2v5_out[4])
  );

  // channel 5 decoder
  range_decode u_dec_ch5 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[11:10]),
    .span_10v_out (span_10v_out[5]),
    .span_5v_out  (span_5v_out[5]),
    .span_2v5_out (span_2v5_out[5])
  );

  // channel 6 decoder
  range_decode u_dec_ch6 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[13:12]),
    .span_10v_out (span_10v_out[6]),
    .span_5v_out  (span_5v_out[6]),
    .span_2v5_out (span_2v5_out[6])
  );

  // channel 7 decoder
  range_decode u_dec_ch7 (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .code_in      (code_vec[15:14]),
    .span_10v_out (span_10v_out[7]),
    .span_5v_out  (span_5v_out[7]),
    .span_2v5_out (span_2v5_out[7])
  );

endmodule

// *** rtl/range_decode.sv ***
// ------------------------------------------------------------------
// one channel: range code to registered span select
// ------------------------------------------------------------------
module range_decode (
  input  wire logic                                clock_in,    // 25 MHz clock
  input  wire logic                                sys_rst_in,  // async reset, active high
  input  wire logic [range_regs_pkg::CODE_W-1:0]   code_in,     // stored range code
  output logic                                     span_10v_out, // +/-10 V selected
  output logic                                     span_5v_out,  // +/-5 V selected
  output logic                                     span_2v5_out  // +/-2.5 V selected
);

  // decode, both 00 and 11 give the widest span
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      span_10v_out <= 1'b1;
      span_5v_out  <= 1'b0;
      span_2v5_out <= 1'b0;
    end else begin
      unique case (range_regs_pkg::range_code_t'(code_in))
        range_regs_pkg::RANGE_2V5: begin
          span_10v_out <= 1'b0;
          span_5v_out  <= 1'b0;
          span_2v5_out <= 1'b1;
        end
        range_regs_pkg::RANGE_5V: begin
          span_10v_out <= 1'b0;
          span_5v_out  <= 1'b1;
          span_2v5_out <= 1'b0;
        end
        range_regs_pkg::RANGE_10V_LOW,
        range_regs_pkg::RANGE_10V: begin
          span_10v_out <= 1'b1;
          span_5v_out  <= 1'b0;
          span_2v5_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** testbench/host_model.sv ***
// ----------------------------------------------------------------
// host controller on the register port
// ----------------------------------------------------------------
module host_model (
  input  wire logic        clock_in,   // bus clock
  input  wire logic [15:0] rd_data_in, // word from device
  output logic      [6:0]  addr_out,   // register address
  output logic      [15:0] data_out,   // write word
  output logic             wr_out,     // write strobe
  output logic             rd_out      // read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    addr_out = 7'h00;
    data_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // write strobe raised for one edge and left high for the next task to drop, address field and reserved zero packed in
  task automatic wr(input logic [6:0] a, input logic [6:0] emb, input logic [7:0] codes);
    addr_out <= a;
    data_out <= {emb, 1'b0, codes};
    rd_out <= 1'b0;
    wr_out <= 1'b1;
    @(posedge clock_in);
  endtask
  // one-cycle read, word taken in the following cycle
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    addr_out <= a;
    data_out <= ~data_out;
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    // word stands in this cycle, taken at its closing edge
    @(posedge clock_in);
    d = rd_data_in;
  endtask
endmodule

// *** testbench/range_regs_assertions.sv ***
// ----------------------------------------------------------------
// register bank port checks
// ----------------------------------------------------------------
module range_regs_assertions (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [6:0]  addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        wr_strobe_in,
  input wire logic        rd_strobe_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic        wr_done_out,
  input wire logic        wr_refused_out,
  input wire logic [1:0]  second_conv_ch0_range_out,
  input wire logic [1:0]  second_conv_ch7_range_out,
  input wire logic [7:0]  span_10v_out,
  input wire logic [7:0]  span_5v_out,
  input wire logic [7:0]  span_2v5_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic       ok_w;
  logic [1:0] c0;
  logic [1:0] c7;
  // write with matching embedded address on a mapped register
  assign ok_w = wr_strobe_in && wr_data_in[15:9] == addr_in && (addr_in == 7'h06 || addr_in == 7'h07);
  assign c0 = second_conv_ch0_range_out;
  assign c7 = second_conv_ch7_range_out;
  a_read_valid: assert property (
    rd_strobe_in |=> rd_valid_out) else $error("read strobe not answered");
  a_valid_cause: assert property (
    rd_valid_out |-> $past(rd_strobe_in)) else $error("read valid without strobe");
  a_low_write: assert property (
    ok_w && addr_in == 7'h06 |=> c0 == $past(wr_data_in[1:0]) && wr_done_out) else $error("low write lost");
  a_high_write: assert property (
    ok_w && addr_in == 7'h07 |=> c7 == $past(wr_data_in[7:6]) && wr_done_out) else $error("high write lost");
  a_refused_write: assert property (
    wr_strobe_in && !ok_w |=> wr_refused_out && !wr_done_out && $stable(c0) && $stable(c7))
    else $error("bad write not refused");
  a_span_decode: assert property (
    span_5v_out[0] == ($past(c0) == 2'h2) && span_2v5_out[7] == ($past(c7) == 2'h1) &&
    span_10v_out[0] == ($past(c0) inside {2'h0, 2'h3})) else $error("span decode wrong");
  a_reset_codes: assert property (
    $fell(sys_rst_in) |-> c0 == 2'h3 && c7 == 2'h3 && span_10v_out == 8'hff) else $error("reset codes wrong");
  a_read_back: assert property (
    rd_strobe_in && addr_in == 7'h07 |=> rd_data_out[7:6] == $past(c7)) else $error("read back wrong");
  c_good_write: cover property (ok_w);
  c_bad_write: cover property (wr_strobe_in && !ok_w);
  c_read: cover property (rd_strobe_in ##1 rd_valid_out);
endmodule

// *** testbench/tb.sv ***
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
// ----------------------------------------------------------------
// range register bench
// ----------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in, sys_rst_in, wr_strobe_in, rd_strobe_in;
  logic        rd_valid_out, wr_done_out, wr_refused_out;
  logic [6:0]  addr_in;
  logic [15:0] wr_data_in, rd_data_out, got;
  logic [1:0]  ch [8];
  logic [7:0]  span_10v_out, span_5v_out, span_2v5_out, lo, hi;
  int          errors, check_count;
  host_model host (.clock_in, .rd_data_in(rd_data_out), .addr_out(addr_in), .data_out(wr_data_in),
    .wr_out(wr_strobe_in), .rd_out(rd_strobe_in));
  b_side_input_range_regs dut (.clock_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in,
    .rd_data_out, .rd_valid_out, .wr_done_out, .wr_refused_out, .second_conv_ch0_range_out(ch[0]),
    .second_conv_ch1_range_out(ch[1]), .second_conv_ch2_range_out(ch[2]), .second_conv_ch3_range_out(ch[3]),
    .second_conv_ch4_range_out(ch[4]), .second_conv_ch5_range_out(ch[5]), .second_conv_ch6_range_out(ch[6]),
    .second_conv_ch7_range_out(ch[7]), .span_10v_out, .span_5v_out, .span_2v5_out);
  // verdict and end of run
  task automatic close_out;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // channel codes and span selects against two register words
  task automatic check_spans(input logic [15:0] lw, input logic [15:0] hw);
    logic [1:0] c;
    logic [7:0] e10, e5, e25;
    for (int i = 0; i < 8; i++) begin
      c = (i < 4) ? lw[2*(i%4)+:2] : hw[2*(i%4)+:2];
      `CHK(ch[i], c)
      e10[i] = (c == 2'h0) || (c == 2'h3);
      e5[i] = (c == 2'h2);
      e25[i] = (c == 2'h1);
    end
    `CHK(span_10v_out, e10)
    `CHK(span_5v_out, e5)
    `CHK(span_2v5_out, e25)
  endtask
  // free-running clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // hang guard
  initial begin
    #100000;
    errors++;
    close_out;
  end
  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    sys_rst_in = 1'b1;
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    host.rd(7'h06, got);
    `CHK(got, 16'h00ff)
    host.rd(7'h07, got);
    `CHK(got, 16'h00ff)
    check_spans(16'h00ff, 16'h00ff);
    for (int k = 0; k < 4; k++) begin
      lo = {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)};
      hi = {lo[1:0], lo[7:2]};
      host.wr(7'h06, 7'h06, lo);
      host.wr(7'h07, 7'h07, hi);
      host.rd(7'h06, got);
      `CHK(got, {7'h06, 1'b0, lo})
      host.rd(7'h07, got);
      `CHK(got, {7'h07, 1'b0, hi})
      check_spans({7'h06, 1'b0, lo}, {7'h07, 1'b0, hi});
    end
    host.wr(7'h06, 7'h07, 8'h00);
    host.wr(7'h08, 7'h08, 8'h00);
    host.rd(7'h06, got);
    `CHK(got, {7'h06, 1'b0, lo})
    host.rd(7'h08, got);
    `CHK(got, 16'h0000)
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    host.rd(7'h07, got);
    `CHK(got, 16'h00ff)
    close_out;
  end
endmodule
bind b_side_input_range_regs range_regs_assertions chk (.clock_in, .sys_rst_in, .addr_in, .wr_data_in,
  .wr_strobe_in, .rd_strobe_in, .rd_data_out, .rd_valid_out, .wr_done_out, .wr_refused_out,
  .second_conv_ch0_range_out, .second_conv_ch7_range_out, .span_10v_out, .span_5v_out, .span_2v5_out);
